// ===== design/chan_seq.sv
`timescale 1ns/10ps
`default_nettype none
module chan_seq
  import energize_pkg::*;
(
  input  wire logic       mclk,      // system clock
  input  wire logic       reset,     // synchronous, active high
  input  wire logic       enable,    // this channel's output-enable bit
  input  wire logic       timer_en,  // timer enable bit
  input  wire logic [2:0] duty,      // chop duty code
  input  wire logic [3:0] code,      // energize time code
  input  wire logic       ms_tick,   // one pulse per millisecond
  input  wire logic [2:0] phase,     // pwm slot index
  input  wire logic       pwm_start, // pwm start command pulse
  output logic            drive      // channel switched on
);
  typedef struct packed {
    chan_state_t st;
    logic        en_p;
    logic [8:0]  ms_left;
    logic        drive;
  } chan_t;

  localparam chan_t CHAN_RST = '{st: ST_IDLE, en_p: 1'b0, ms_left: 9'h000, drive: 1'b0};

  chan_t c_q;
  chan_t c_d;

  // the millisecond tick is shared, so energizing lasts between T and T+1 ms
  always_comb begin
    c_d = c_q;
    c_d.en_p = enable;
    if (!enable) begin
      c_d.st = ST_IDLE;
    end else if (!c_q.en_p) begin
      c_d.ms_left = ENERGIZE_MS[code];
      if (code != 4'h0)
        c_d.st = ST_ENERGIZE;
      else if (timer_en)
        c_d.st = ST_CHOP;
      else
        c_d.st = ST_HOLD;
    end else begin
      case (c_q.st)
        ST_ENERGIZE: begin
          if (pwm_start) begin
            c_d.st = ST_CHOP;
          end else if (ms_tick) begin
            if (c_q.ms_left != 9'h000)
              c_d.ms_left = c_q.ms_left - 9'h001;
            else if (!timer_en)
              c_d.st = ST_HOLD;
            else if (duty != 3'h0)
              c_d.st = ST_CHOP;
            else
              c_d.st = ST_OFF;
          end
        end
        default: ;
      endcase
    end
    case (c_d.st)
      ST_ENERGIZE, ST_HOLD: c_d.drive = 1'b1;
      ST_CHOP:              c_d.drive = (phase < duty);
      default:              c_d.drive = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset)
      c_q <= CHAN_RST;
    else
      c_q <= c_d;
  end

  assign drive = c_q.drive;

  property p_chop_direct;
    @(posedge mclk) disable iff (reset)
    (enable && !c_q.en_p && timer_en && code == 4'h0) |=> (c_q.st == ST_CHOP);
  endproperty
  a_chop_direct: assert property (p_chop_direct) else $error("direct chop not entered");

  property p_hold_full_on;
    @(posedge mclk) disable iff (reset)
    (c_q.st == ST_HOLD && enable) |=> c_q.drive;
  endproperty
  a_hold_full_on: assert property (p_hold_full_on) else $error("held output not on");

  property p_off_after_energize;
    @(posedge mclk) disable iff (reset)
    (c_q.st == ST_ENERGIZE && enable && ms_tick && !pwm_start && c_q.ms_left == 9'h000
     && timer_en && duty == 3'h0) |=> (c_q.st == ST_OFF && !c_q.drive);
  endproperty
  a_off_after_energize: assert property (p_off_after_energize) else $error("not off");

  property p_late_start_ignored;
    @(posedge mclk) disable iff (reset)
    (c_q.st == ST_HOLD && enable && pwm_start) |=> (c_q.st == ST_HOLD) [*2];
  endproperty
  a_late_start_ignored: assert property (p_late_start_ignored) else $error("late start");

  property p_idle_when_off;
    @(posedge mclk) disable iff (reset)
    !enable |=> (c_q.st == ST_IDLE && !c_q.drive);
  endproperty
  a_idle_when_off: assert property (p_idle_when_off) else $error("disabled channel active");

  property p_start_cuts;
    @(posedge mclk) disable iff (reset)
    (c_q.st == ST_ENERGIZE && enable && c_q.en_p && pwm_start) |=> (c_q.st == ST_CHOP);
  endproperty
  a_start_cuts: assert property (p_start_cuts) else $error("pwm start missed");

  c_chop_after_energize: cover property (@(posedge mclk) disable iff (reset)
    (c_q.st == ST_ENERGIZE) ##1 (c_q.st == ST_CHOP));
endmodule // chan_seq
`default_nettype wire

// ===== design/energize_pkg.sv
package energize_pkg;
  localparam int CLK_PERIOD_NS   = 25;
  localparam int MS_NS           = 1000000;
  localparam int MS_CYCLES       = MS_NS / CLK_PERIOD_NS;
  localparam int MS_CNT_W        = 24;
  localparam int PWM_PERIOD_NS   = 80000;
  localparam int PWM_STEPS       = 8;
  localparam int PWM_SLOT_CYCLES = PWM_PERIOD_NS / CLK_PERIOD_NS / PWM_STEPS;
  localparam int SLOT_CNT_W      = 9;
  localparam int CHANNELS        = 8;
  localparam int TIMER_EN_POS    = 7;
  localparam int DUTY_LSB        = 4;
  localparam int ENERGIZE_LSB    = 0;
  localparam int OVERCURRENT_LSB = 8;
  localparam int OPEN_LOAD_LSB   = 0;
  localparam logic [7:0]  ENABLE_RESET = 8'h00;
  localparam logic [7:0]  SETUP_RESET  = 8'h00;
  localparam logic [15:0] FLAGS_RESET  = 16'h0000;
  // energizing time in milliseconds per code
  localparam logic [8:0] ENERGIZE_MS [16] = '{
    9'h000, 9'h003, 9'h005, 9'h00a, 9'h00f, 9'h014, 9'h01e, 9'h032,
    9'h050, 9'h06e, 9'h08c, 9'h0aa, 9'h0c8, 9'h0e6, 9'h104, 9'h12c
  };
  typedef enum logic [2:0] {
    CMD_WR_ENABLE, CMD_RD_ENABLE, CMD_WR_SETUP, CMD_RD_SETUP,
    CMD_RD_FLAGS, CMD_FLAGS_CLEAR, CMD_PWM_START
  } cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ENERGIZE, ST_CHOP, ST_OFF, ST_HOLD
  } chan_state_t;
endpackage

// ===== design/energize_pwm_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module energize_pwm_ctrl
  import energize_pkg::*;
#(
  parameter int unsigned MS_TICK_CYCLES  = MS_CYCLES,
  parameter bit          OPEN_LOAD_SENSE = 1'b1
) (
  input  wire logic       mclk,            // system clock, 40 MHz
  input  wire logic       reset,           // synchronous, active high
  input  wire logic       link_clk,        // serial link clock
  input  wire logic       cmd_strobe,      // link domain: command valid
  input  wire logic [2:0] cmd_kind,        // link domain: command code
  input  wire logic [7:0] cmd_word,        // link domain: write data
  output logic            cmd_ready,       // link domain: command may be given
  output logic            shift_load,      // link domain: readback word valid
  output logic [15:0]     shift_word,      // link domain: readback word
  input  wire logic [7:0] overcurrent_det, // async overcurrent sense
  input  wire logic [7:0] open_load_det,   // async open-load sense
  output logic [7:0]      channel_output,  // channel drive, bit 0 is channel one
  output logic            fault_alarm_n    // low while any fault flag is set
);
  typedef struct packed {
    logic        rst_m;
    logic        rst;
    logic        req;
    logic [2:0]  kind;
    logic [7:0]  word;
    logic        ack_m;
    logic        ack_s;
    logic        ack_p;
    logic        ready;
    logic        load;
    logic [15:0] shift;
  } link_t;

  typedef struct packed {
    logic                  req_m;
    logic                  req_s;
    logic                  req_p;
    logic                  ack;
    logic [15:0]           rd_word;
    logic [7:0]            oc_m;
    logic [7:0]            oc_s;
    logic [7:0]            ol_m;
    logic [7:0]            ol_s;
    logic [7:0]            enable;
    logic [7:0]            setup;
    logic [15:0]           flags;
    logic                  alarm_n;
    logic [MS_CNT_W-1:0]   ms_cnt;
    logic                  ms_tick;
    logic [SLOT_CNT_W-1:0] slot_cnt;
    logic [2:0]            phase;
    logic                  pwm_start;
  } main_t;

  localparam logic [MS_CNT_W-1:0]   MS_LAST   = MS_CNT_W'(MS_TICK_CYCLES - 1);
  localparam logic [SLOT_CNT_W-1:0] SLOT_LAST = SLOT_CNT_W'(PWM_SLOT_CYCLES - 1);

  link_t l_q;
  link_t l_d;
  main_t m_q;
  main_t m_d;

  logic        new_cmd;
  cmd_t        kind;
  logic [15:0] clr;
  logic [15:0] set;

  // link side: a toggle request carries one command across; the word and
  // kind are held until the echo returns, which also marks readback data
  always_comb begin
    l_d = l_q;
    l_d.load = 1'b0;
    l_d.ack_m = m_q.ack;
    l_d.ack_s = l_q.ack_m;
    if (l_q.rst) begin
      l_d.req = 1'b0;
      l_d.kind = 3'h0;
      l_d.word = 8'h00;
      l_d.ack_p = 1'b0;
      l_d.ready = 1'b0;
      l_d.shift = 16'h0000;
    end else begin
      if (l_q.ack_s != l_q.ack_p) begin
        l_d.ack_p = l_q.ack_s;
        if (l_q.kind == CMD_RD_ENABLE || l_q.kind == CMD_RD_SETUP
            || l_q.kind == CMD_RD_FLAGS) begin
          l_d.load = 1'b1;
          l_d.shift = m_q.rd_word;
        end
      end
      if (cmd_strobe && l_q.ready) begin
        l_d.req = ~l_q.req;
        l_d.kind = cmd_kind;
        l_d.word = cmd_word;
      end
      l_d.ready = (l_d.req == l_d.ack_p) && !(cmd_strobe && l_q.ready);
    end
    l_d.rst_m = reset;
    l_d.rst = l_q.rst_m;
  end

  always_ff @(posedge link_clk) begin
    l_q <= l_d;
  end

  assign cmd_ready  = l_q.ready;
  assign shift_load = l_q.load;
  assign shift_word = l_q.shift;

  always_comb begin
    m_d = m_q;
    m_d.req_m = l_q.req;
    m_d.req_s = m_q.req_m;
    m_d.req_p = m_q.req_s;
    m_d.ack = m_q.req_s;
    m_d.oc_m = overcurrent_det;
    m_d.oc_s = m_q.oc_m;
    m_d.ol_m = open_load_det;
    m_d.ol_s = m_q.ol_m;
    m_d.ms_tick = 1'b0;
    m_d.pwm_start = 1'b0;
    new_cmd = (m_q.req_s != m_q.req_p);
    kind = cmd_t'(l_q.kind);
    clr = 16'h0000;
    if (new_cmd) begin
      case (kind)
        CMD_WR_ENABLE: begin
          m_d.enable = l_q.word;
          clr = {~l_q.word, l_q.word};
        end
        CMD_RD_ENABLE:   m_d.rd_word = {8'h00, m_q.enable};
        CMD_WR_SETUP:    m_d.setup = l_q.word;
        CMD_RD_SETUP:    m_d.rd_word = {8'h00, m_q.setup};
        CMD_RD_FLAGS:    m_d.rd_word = m_q.flags;
        CMD_FLAGS_CLEAR: clr = 16'hffff;
        CMD_PWM_START:   m_d.pwm_start = 1'b1;
        default: ;
      endcase
    end
    // a fault seen in the clearing cycle survives the clear
    set = {m_q.oc_s, OPEN_LOAD_SENSE ? m_q.ol_s : 8'h00};
    m_d.flags = (m_q.flags & ~clr) | set;
    m_d.alarm_n = ~|m_d.flags;
    if (m_q.ms_cnt == MS_LAST) begin
      m_d.ms_cnt = '0;
      m_d.ms_tick = 1'b1;
    end else begin
      m_d.ms_cnt = m_q.ms_cnt + 1'b1;
    end
    if (m_q.slot_cnt == SLOT_LAST) begin
      m_d.slot_cnt = '0;
      m_d.phase = m_q.phase + 3'h1;
    end else begin
      m_d.slot_cnt = m_q.slot_cnt + 1'b1;
    end
    if (reset) begin
      m_d.ack = 1'b0;
      m_d.req_p = 1'b0;
      m_d.req_s = 1'b0;
      m_d.req_m = 1'b0;
      m_d.rd_word = 16'h0000;
      m_d.enable = ENABLE_RESET;
      m_d.setup = SETUP_RESET;
      m_d.flags = FLAGS_RESET;
      m_d.alarm_n = 1'b1;
      m_d.ms_cnt = '0;
      m_d.slot_cnt = '0;
      m_d.phase = 3'h0;
    end
  end

  always_ff @(posedge mclk) begin
    m_q <= m_d;
  end

  assign fault_alarm_n = m_q.alarm_n;

  for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
    chan_seq u_chan (
      .mclk      (mclk),
      .reset     (reset),
      .enable    (m_q.enable[i]),
      .timer_en  (m_q.setup[TIMER_EN_POS]),
      .duty      (m_q.setup[DUTY_LSB +: 3]),
      .code      (m_q.setup[ENERGIZE_LSB +: 4]),
      .ms_tick   (m_q.ms_tick),
      .phase     (m_q.phase),
      .pwm_start (m_q.pwm_start),
      .drive     (channel_output[i])
    );
  end

  property p_alarm_on_fault;
    @(posedge mclk) disable iff (reset)
    (|m_q.oc_s) |=> !fault_alarm_n;
  endproperty
  a_alarm_on_fault: assert property (p_alarm_on_fault) else $error("alarm not low");

  property p_alarm_release;
    @(posedge mclk) disable iff (reset)
    (m_q.flags == 16'h0000) |-> fault_alarm_n;
  endproperty
  a_alarm_release: assert property (p_alarm_release) else $error("alarm stuck low");

  property p_flags_clear;
    @(posedge mclk) disable iff (reset)
    (new_cmd && kind == CMD_FLAGS_CLEAR && m_q.oc_s == 8'h00 && m_q.ol_s == 8'h00)
      |=> (m_q.flags == 16'h0000);
  endproperty
  a_flags_clear: assert property (p_flags_clear) else $error("flags not cleared");

  property p_enable_clears;
    @(posedge mclk) disable iff (reset)
    (new_cmd && kind == CMD_WR_ENABLE && m_q.oc_s == 8'h00 && m_q.ol_s == 8'h00)
      |=> ((m_q.flags[7:0] & m_q.enable) == 8'h00
           && (m_q.flags[15:8] & ~m_q.enable) == 8'h00);
  endproperty
  a_enable_clears: assert property (p_enable_clears) else $error("flag not cleared");

  property p_setup_reset;
    @(posedge mclk) reset |=> !m_q.setup[TIMER_EN_POS];
  endproperty
  a_setup_reset: assert property (p_setup_reset) else $error("timer enable set");

  property p_setup_only_by_cmd;
    @(posedge mclk) disable iff (reset)
    !(new_cmd && kind == CMD_WR_SETUP) |=> $stable(m_q.setup);
  endproperty
  a_setup_only_by_cmd: assert property (p_setup_only_by_cmd) else $error("setup moved");

  property p_enable_only_by_cmd;
    @(posedge mclk) disable iff (reset)
    !(new_cmd && kind == CMD_WR_ENABLE) |=> $stable(m_q.enable);
  endproperty
  a_enable_only_by_cmd: assert property (p_enable_only_by_cmd) else $error("enable moved");

  property p_readback;
    @(posedge mclk) disable iff (reset)
    (new_cmd && kind == CMD_RD_ENABLE) |=> (m_q.rd_word == {8'h00, m_q.enable});
  endproperty
  a_readback: assert property (p_readback) else $error("readback word wrong");

  property p_no_open_load;
    @(posedge mclk) disable iff (reset)
    !OPEN_LOAD_SENSE |-> (m_q.flags[7:0] == 8'h00);
  endproperty
  a_no_open_load: assert property (p_no_open_load) else $error("open-load flag");

  property p_alarm_open_load;
    @(posedge mclk) disable iff (reset)
    (OPEN_LOAD_SENSE && |m_q.ol_s) |=> !fault_alarm_n;
  endproperty
  a_alarm_open_load: assert property (p_alarm_open_load) else $error("alarm not low");

  property p_enable_write;
    @(posedge mclk) disable iff (reset)
    (new_cmd && kind == CMD_WR_ENABLE) |=> (m_q.enable == $past(l_q.word));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost");

  property p_setup_readback;
    @(posedge mclk) disable iff (reset)
    (new_cmd && kind == CMD_RD_SETUP) |=> (m_q.rd_word == {8'h00, m_q.setup});
  endproperty
  a_setup_readback: assert property (p_setup_readback) else $error("setup word wrong");

  property p_flags_readback;
    @(posedge mclk) disable iff (reset)
    (new_cmd && kind == CMD_RD_FLAGS) |=> (m_q.rd_word == $past(m_q.flags));
  endproperty
  a_flags_readback: assert property (p_flags_readback) else $error("flag word wrong");

  property p_start_pulse;
    @(posedge mclk) disable iff (reset)
    (new_cmd && kind == CMD_PWM_START) |=> m_q.pwm_start ##1 !m_q.pwm_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("pwm start not one pulse");

  c_flags_clear: cover property (@(posedge mclk) disable iff (reset)
    new_cmd && kind == CMD_FLAGS_CLEAR && m_q.flags != 16'h0000);
  c_pwm_start: cover property (@(posedge mclk) disable iff (reset)
    new_cmd && kind == CMD_PWM_START && m_q.enable != 8'h00);
  c_readback: cover property (@(posedge mclk) disable iff (reset)
    new_cmd && kind == CMD_RD_ENABLE);
endmodule // energize_pwm_ctrl
`default_nettype wire

// ===== test/link_host.sv
`timescale 1ns/10ps
`default_nettype none
module link_host (
  input  wire logic        link_clk,   // link clock
  input  wire logic        cmd_ready,  // device may take a command
  input  wire logic        shift_load, // readback valid pulse
  input  wire logic [15:0] shift_word, // readback word
  output logic             cmd_strobe, // command valid
  output logic [2:0]       cmd_kind,   // command code
  output logic [7:0]       cmd_word    // write data
);
  int lost = 0;

  initial begin
    cmd_strobe = 1'b0;
    cmd_kind   = 3'h7;
    cmd_word   = 8'h00;
  end

  // sampled at the falling edge, where the registered levels are settled
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(negedge link_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 400);
    if (n >= 400) begin
      $display("ERROR cmd_ready expected 1 seen %b", cmd_ready);
      lost++;
    end
  endtask

  // one command outstanding at a time; readback word arrives with its pulse
  task automatic send(input logic [2:0] kind, input logic [7:0] word, input bit is_read,
                      output logic [15:0] rd);
    int n;
    rd = 16'hffff;
    wait_ready();
    cmd_strobe = 1'b1;
    cmd_kind   = kind;
    cmd_word   = word;
    @(posedge link_clk);
    @(negedge link_clk);
    cmd_strobe = 1'b0;
    // released lines carry the inverse so a stale value cannot pass for data
    cmd_kind   = ~kind;
    cmd_word   = ~word;
    if (is_read) begin
      n = 0;
      do begin
        @(negedge link_clk);
        n++;
      end while (shift_load !== 1'b1 && n < 400);
      if (n >= 400) begin
        $display("ERROR shift_load expected 1 seen %b", shift_load);
        lost++;
      end
      rd = shift_word;
    end
    wait_ready();
  endtask
endmodule // link_host
`default_nettype wire

// ===== test/octal_energize_pwm_output_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module octal_energize_pwm_output_control_bench;
  import energize_pkg::*;
  logic        mclk;
  logic        reset;
  logic        link_clk;
  logic        cmd_strobe;
  logic [2:0]  cmd_kind;
  logic [7:0]  cmd_word;
  logic        cmd_ready;
  logic        shift_load;
  logic [15:0] shift_word;
  logic [15:0] shift_word_b;
  logic [7:0]  overcurrent_det;
  logic [7:0]  open_load_det;
  logic [7:0]  channel_output;
  logic        fault_alarm_n;
  int          fails = 0;
  int          tests_run = 0;

  energize_pwm_ctrl #(.MS_TICK_CYCLES(20), .OPEN_LOAD_SENSE(1'b1)) dut_u (
    .mclk(mclk), .reset(reset), .link_clk(link_clk), .cmd_strobe(cmd_strobe),
    .cmd_kind(cmd_kind), .cmd_word(cmd_word), .cmd_ready(cmd_ready),
    .shift_load(shift_load), .shift_word(shift_word), .overcurrent_det(overcurrent_det),
    .open_load_det(open_load_det), .channel_output(channel_output),
    .fault_alarm_n(fault_alarm_n));

  // variant without open-load sensing on the same link; its readback word
  // stands in the same cycles as that of the first part
  energize_pwm_ctrl #(.MS_TICK_CYCLES(20), .OPEN_LOAD_SENSE(1'b0)) dut_oc_only_u (
    .mclk(mclk), .reset(reset), .link_clk(link_clk), .cmd_strobe(cmd_strobe),
    .cmd_kind(cmd_kind), .cmd_word(cmd_word), .cmd_ready(),
    .shift_load(), .shift_word(shift_word_b), .overcurrent_det(overcurrent_det),
    .open_load_det(open_load_det), .channel_output(), .fault_alarm_n());

  link_host host_u (
    .link_clk(link_clk), .cmd_ready(cmd_ready), .shift_load(shift_load),
    .shift_word(shift_word), .cmd_strobe(cmd_strobe), .cmd_kind(cmd_kind),
    .cmd_word(cmd_word));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // unrelated phase to mclk
  initial begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  task automatic conclude();
    fails += host_u.lost;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  task automatic cmd(input logic [2:0] kind, input logic [7:0] word);
    logic [15:0] rd;
    host_u.send(kind, word, 1'b0, rd);
  endtask

  task automatic rd_chk(input string what, input logic [2:0] kind, input logic [15:0] exp);
    logic [15:0] rd;
    host_u.send(kind, 8'h00, 1'b1, rd);
    chk(what, exp, rd);
  endtask

  // cycles on over a window; a whole pwm period gives duty times one slot
  task automatic on_count(input int ch, input int n, input int exp, input string what);
    int hi;
    hi = 0;
    repeat (2) @(negedge mclk);
    repeat (n) begin
      @(negedge mclk);
      if (channel_output[ch] === 1'b1) hi++;
    end
    chk(what, 16'(exp), 16'(hi));
  endtask

  task automatic pulse_det(input logic [7:0] oc, input logic [7:0] ol);
    @(negedge mclk);
    overcurrent_det = oc;
    open_load_det   = ol;
    repeat (10) @(negedge mclk);
    overcurrent_det = 8'h00;
    open_load_det   = 8'h00;
    repeat (2) @(negedge mclk);
  endtask

  initial begin
    repeat (80000) @(posedge mclk);
    $display("ERROR watchdog expected finish seen hang");
    fails++;
    conclude();
  end

  initial begin
    int period;
    period = PWM_STEPS * PWM_SLOT_CYCLES;
    reset = 1'b1;
    overcurrent_det = 8'h00;
    open_load_det = 8'h00;
    repeat (20) @(negedge mclk);
    reset = 1'b0;
    chk("outputs after reset", 16'h0000, {8'h00, channel_output});
    chk("alarm after reset", 16'h0001, {15'h0000, fault_alarm_n});
    rd_chk("setup reset", CMD_RD_SETUP, 16'h0000);
    rd_chk("enable reset", CMD_RD_ENABLE, 16'h0000);
    rd_chk("flags reset", CMD_RD_FLAGS, 16'h0000);

    cmd(CMD_WR_ENABLE, 8'h01);
    on_count(0, period, period, "always on");
    rd_chk("enable readback", CMD_RD_ENABLE, 16'h0001);

    // the setup must stand before the enable rises: direct chop is chosen at activation
    cmd(CMD_WR_SETUP, 8'h80);
    cmd(CMD_WR_ENABLE, 8'h03);
    for (int d = 0; d < 8; d++) begin
      cmd(CMD_WR_SETUP, {1'b1, 3'(d), 4'h0});
      on_count(1, period, d * PWM_SLOT_CYCLES, "direct chop duty");
    end
    rd_chk("setup readback", CMD_RD_SETUP, 16'h00f0);

    cmd(CMD_WR_SETUP, 8'ha1);
    cmd(CMD_WR_ENABLE, 8'h04);
    on_count(2, 40, 40, "energize then chop");
    repeat (60) @(negedge mclk);
    on_count(2, period, 2 * PWM_SLOT_CYCLES, "chop after energize");

    cmd(CMD_WR_SETUP, 8'h81);
    cmd(CMD_WR_ENABLE, 8'h00);
    cmd(CMD_WR_ENABLE, 8'h04);
    on_count(2, 40, 40, "energize before off");
    repeat (60) @(negedge mclk);
    on_count(2, period, 0, "off after energize");

    cmd(CMD_WR_SETUP, 8'hcf);
    cmd(CMD_WR_ENABLE, 8'h08);
    on_count(3, 100, 100, "long energize");
    cmd(CMD_PWM_START, 8'h00);
    on_count(3, period, 4 * PWM_SLOT_CYCLES, "pwm start cuts energize");

    cmd(CMD_WR_SETUP, 8'h41);
    cmd(CMD_WR_ENABLE, 8'h10);
    on_count(4, 200, 200, "energize past expiry");
    cmd(CMD_PWM_START, 8'h00);
    on_count(4, period, period, "late pwm start ignored");

    cmd(CMD_WR_ENABLE, 8'h00);
    repeat (3) @(negedge mclk);
    chk("outputs idle", 16'h0000, {8'h00, channel_output});

    pulse_det(8'h04, 8'h00);
    chk("alarm on overcurrent", 16'h0000, {15'h0000, fault_alarm_n});
    rd_chk("overcurrent flag", CMD_RD_FLAGS, 16'h0400);
    pulse_det(8'h00, 8'h20);
    rd_chk("open load flag", CMD_RD_FLAGS, 16'h0420);
    chk("variant open load", 16'h0400, shift_word_b);
    // channel three is switched on too so that only the open-load flag of channel six goes
    cmd(CMD_WR_ENABLE, 8'h24);
    rd_chk("enable clears open load", CMD_RD_FLAGS, 16'h0400);
    cmd(CMD_WR_ENABLE, 8'h00);
    rd_chk("disable clears overcurrent", CMD_RD_FLAGS, 16'h0000);
    chk("alarm released", 16'h0001, {15'h0000, fault_alarm_n});
    pulse_det(8'h81, 8'h81);
    rd_chk("both flags", CMD_RD_FLAGS, 16'h8181);
    chk("variant both flags", 16'h8100, shift_word_b);
    cmd(CMD_FLAGS_CLEAR, 8'h00);
    rd_chk("flags cleared", CMD_RD_FLAGS, 16'h0000);
    chk("alarm after clear", 16'h0001, {15'h0000, fault_alarm_n});
    conclude();
  end
endmodule // octal_energize_pwm_output_control_bench
`default_nettype wire
